// >>> src/mhp_cfg.svh
// Overview of operation
// - Hold reset until supply good, wait eight crystal periods
// - Reset pin low restores defaults; release waits eight periods
// - Command 0x80 returns every register to default
// - Stand-by keeps reference/oscillator; power-up returns active
// - Sleep keeps decoder only; power-up reinitializes fully
// - Only masked-in status bits drive interrupt pin
// - Writing one clears status bit; zero keeps it
// - Pulse and polarity selects give four pin formats
// - Interrupt pulse lasts at least one divided clock
// - Each byte decodes as instruction, sync, write, read
// - Instructions abort work but not reads shifting out
// - Sync bytes touch only the serial interface
// - Write takes three data bytes; read returns three
// - Commands and data shift most significant bit first
// - Input accepted during reads; new read ends old
// - Serial clock honoured only while chip select low
// - Chip select, reset, or sync sequence reinitializes port
// - Access byte: 0, write bit, index, 0
// - Write data lands after twenty-fourth data clock
// - Power-down field: reset, stand-by, sleep, reserved
// - Power-up restarts when down, halts when active
`ifndef MHP_CFG_SVH
`define MHP_CFG_SVH
`define MHP_REG_CFG 5'h00
`define MHP_REG_STATUS 5'h0f
`define MHP_REG_MASK 5'h1a
`define MHP_CFG_RST 24'h000001
`define MHP_CFG_IRQ_POL_BIT 4
`define MHP_CFG_IRQ_PULSE_BIT 5
`define MHP_READY_BIT 23
`define MHP_INIT_LAST 3'h7
`define MHP_PULSE_TICKS 2'h2
`define MHP_SYNC_MIN 2'h3
`define MHP_CMD_FILLER 8'hff
`define MHP_CMD_FINAL 8'hfe
`define MHP_CMD_PWRUP 8'ha0
`define MHP_CMD_PD_MASK 8'he7
`define MHP_CMD_PD_BASE 8'h80
`define MHP_CMD_START_MASK 8'hf7
`define MHP_CMD_START_BASE 8'he0
`define MHP_P_CS 0
`define MHP_P_SCLK 1
`define MHP_P_SDI 2
`define MHP_P_XTAL 3
`define MHP_P_RST 4
`define MHP_P_VGOOD 5
`define MHP_PIN_RST 6'h01
`endif

// >>> src/mhp_pkg.sv
package mhp_pkg;
    typedef enum logic [1:0] {PS_RST_WAIT, PS_ACTIVE, PS_STANDBY, PS_SLEEP} mhp_pwr_t;
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } mhp_spi_t;
    typedef struct packed {
        logic core_on;
        logic ref_osc_on;
        logic halt;
        logic start;
        logic continuous;
        logic device_ready;
        logic [23:0] config_word;
    } mhp_ctl_t;
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] pin;
        logic [5:0] pinp;
        mhp_pwr_t pst;
        logic [2:0] xcnt;
        logic [3:0] kcnt;
        logic [31:0][23:0] regs;
        logic [7:0] rx;
        logic [2:0] bitc;
        logic [1:0] wleft;
        logic [4:0] waddr;
        logic [15:0] wdata;
        logic [31:0] tx;
        logic fresh;
        logic [1:0] ffcnt;
        logic [23:0] pendv;
        logic [1:0] pcnt;
        logic irq;
        logic halt;
        logic start;
        logic continuous;
    } mhp_state_t;
endpackage

// >>> src/mhp_port_ctrl.sv
`timescale 1ns/100ps
`include "mhp_cfg.svh"
module mhp_port_ctrl (
    // Clock, reset and enable
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Serial command port
    input wire mhp_pkg::mhp_spi_t spi_i,
    output logic sdo_o,
    // Reset, supply and crystal pins
    input wire logic hw_reset_n_i,
    input wire logic analog_good_i,
    input wire logic crystal_input_i,
    // Measurement core
    input wire logic [23:0] event_i,
    output mhp_pkg::mhp_ctl_t ctl_o,
    output logic irq_out_pin_o
);
    import mhp_pkg::*;

    mhp_state_t q, d;
    logic [5:0] raw;
    logic xrise, srise, sfall, cs_act, tick, ireset, sreset, device_ready_flag_set;
    logic wr_stb, resync, byte_done, rd_load;
    logic [7:0] byte_v;
    logic [23:0] wval, clr, cfg, stat, cur;
    logic [3:0] kdiv;
    logic active_v;

    function automatic logic is_access(input logic [7:0] b);
        return !b[7] && !b[0];
    endfunction

    assign raw = {analog_good_i, hw_reset_n_i, crystal_input_i, spi_i.sdi, spi_i.sclk, spi_i.cs_n};
    assign cfg = q.regs[`MHP_REG_CFG];
    assign stat = q.regs[`MHP_REG_STATUS];
    assign kdiv = cfg[3:0];

    always_comb begin
        d = q;
        wr_stb = 1'b0;
        resync = 1'b0;
        rd_load = 1'b0;
        sreset = 1'b0;
        device_ready_flag_set = 1'b0;
        tick = 1'b0;
        clr = '0;
        wval = '0;
        byte_v = {q.rx[6:0], q.pin[`MHP_P_SDI]};
        d.halt = 1'b0;
        d.start = 1'b0;
        // Pin filter: a change counts once stages two and three agree
        d.s1 = raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.pinp = q.pin;
        for (int i = 0; i < 6; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.pin[i] = q.s2[i];
            end
        end
        xrise = q.pin[`MHP_P_XTAL] & ~q.pinp[`MHP_P_XTAL];
        srise = q.pin[`MHP_P_SCLK] & ~q.pinp[`MHP_P_SCLK];
        sfall = ~q.pin[`MHP_P_SCLK] & q.pinp[`MHP_P_SCLK];
        cs_act = ~q.pin[`MHP_P_CS];
        ireset = ~q.pin[`MHP_P_RST] | ~q.pin[`MHP_P_VGOOD];
        // Divided core clock: one tick per K rising crystal edges, K of 0 means 16
        if (xrise) begin
            if (q.kcnt == kdiv - 4'h1) begin
                d.kcnt = '0;
                tick = 1'b1;
            end else begin
                d.kcnt = q.kcnt + 4'h1;
            end
        end
        // Wait eight crystal periods before running the initialization
        if (q.pst == PS_RST_WAIT && xrise) begin
            if (q.xcnt == `MHP_INIT_LAST) begin
                d.pst = PS_ACTIVE;
                device_ready_flag_set = 1'b1;
            end else begin
                d.xcnt = q.xcnt + 3'h1;
            end
        end
        byte_done = 1'b0;
        if (!cs_act) begin
            d.bitc = '0;
            d.wleft = '0;
            d.ffcnt = '0;
            d.tx = '0;
            d.fresh = 1'b0;
        end else begin
            if (sfall) begin
                if (!q.fresh) begin
                    d.tx = {q.tx[30:0], 1'b0};
                end
                d.fresh = 1'b0;
            end
            if (srise) begin
                d.rx = byte_v;
                d.bitc = q.bitc + 3'h1;
                byte_done = (q.bitc == 3'h7) && (q.pst != PS_RST_WAIT);
            end
        end
        active_v = (q.pst == PS_ACTIVE);
        // Command decoder: write data, sync, access or instruction
        if (byte_done) begin
            if (q.wleft != 2'h0) begin
                d.wdata = {q.wdata[7:0], byte_v};
                d.wleft = q.wleft - 2'h1;
                if (q.wleft == 2'h1) begin
                    wr_stb = 1'b1;
                    wval = {q.wdata, byte_v};
                end
            end else if (byte_v == `MHP_CMD_FILLER) begin
                if (q.ffcnt != 2'h3) begin
                    d.ffcnt = q.ffcnt + 2'h1;
                end
            end else if (byte_v == `MHP_CMD_FINAL) begin
                d.ffcnt = '0;
                resync = (q.ffcnt >= `MHP_SYNC_MIN);
            end else begin
                d.ffcnt = '0;
                if (is_access(byte_v)) begin
                    if (active_v && byte_v[6]) begin
                        d.wleft = 2'h3;
                        d.waddr = byte_v[5:1];
                    end else if (active_v) begin
                        rd_load = 1'b1;
                        d.tx = {q.regs[byte_v[5:1]], 8'h00};
                        d.fresh = 1'b1;
                    end
                end else if (!byte_v[7]) begin
                    d.ffcnt = '0;
                end else if (byte_v == `MHP_CMD_PWRUP) begin
                    case (q.pst)
                        PS_STANDBY: d.pst = PS_ACTIVE;
                        PS_SLEEP: sreset = 1'b1;
                        default: d.halt = 1'b1;
                    endcase
                end else if ((byte_v & `MHP_CMD_PD_MASK) == `MHP_CMD_PD_BASE) begin
                    d.halt = 1'b1;
                    case (byte_v[4:3])
                        2'h0: sreset = 1'b1;
                        2'h1: d.pst = PS_STANDBY;
                        2'h2: d.pst = PS_SLEEP;
                        default: d.halt = 1'b1;
                    endcase
                end else if (active_v && (byte_v & `MHP_CMD_START_MASK) == `MHP_CMD_START_BASE) begin
                    d.halt = 1'b1;
                    d.start = 1'b1;
                    d.continuous = byte_v[3];
                end
            end
        end
        if (resync) begin
            d.wleft = '0;
        end
        if (wr_stb) begin
            if (q.waddr == `MHP_REG_STATUS) begin
                clr = wval;
            end else begin
                d.regs[q.waddr] = wval;
            end
        end
        // Status: the event wins over a clear in the same cycle
        d.regs[`MHP_REG_STATUS] = (stat & ~clr) | event_i;
        if (device_ready_flag_set) begin
            d.regs[`MHP_REG_STATUS][`MHP_READY_BIT] = 1'b1;
        end
        // Interrupt pin format
        cur = stat & q.regs[`MHP_REG_MASK];
        d.pendv = cur;
        if (|(cur & ~q.pendv)) begin
            d.pcnt = `MHP_PULSE_TICKS;
        end else if (tick && q.pcnt != 2'h0) begin
            d.pcnt = q.pcnt - 2'h1;
        end
        if (cfg[`MHP_CFG_IRQ_PULSE_BIT]) begin
            d.irq = (q.pcnt != 2'h0) ~^ cfg[`MHP_CFG_IRQ_POL_BIT];
        end else begin
            d.irq = (|cur) ~^ cfg[`MHP_CFG_IRQ_POL_BIT];
        end
        if (ireset || sreset) begin
            d.regs = '0;
            d.regs[`MHP_REG_CFG] = `MHP_CFG_RST;
            // A soft reset must not swallow an event of the same cycle
            if (!ireset) begin
                d.regs[`MHP_REG_STATUS] = event_i;
            end
            d.pst = PS_RST_WAIT;
            d.xcnt = '0;
            d.pcnt = '0;
            d.pendv = '0;
            d.continuous = 1'b0;
        end
        if (ireset) begin
            d.bitc = '0;
            d.wleft = '0;
            d.tx = '0;
            d.ffcnt = '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.regs[`MHP_REG_CFG] <= `MHP_CFG_RST;
            q.pin <= `MHP_PIN_RST;
            q.pinp <= `MHP_PIN_RST;
            q.irq <= 1'b1;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign sdo_o = q.tx[31];
    assign irq_out_pin_o = q.irq;
    assign ctl_o.core_on = (q.pst == PS_ACTIVE);
    assign ctl_o.ref_osc_on = (q.pst == PS_ACTIVE) || (q.pst == PS_STANDBY);
    assign ctl_o.halt = q.halt;
    assign ctl_o.start = q.start;
    assign ctl_o.continuous = q.continuous;
    assign ctl_o.device_ready = stat[`MHP_READY_BIT];
    assign ctl_o.config_word = cfg;

    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_IRQ_LEVEL: assert property (
        $past(ce_i) && !$past(cfg[`MHP_CFG_IRQ_PULSE_BIT]) && $past(|cur)
        |-> irq_out_pin_o == $past(cfg[`MHP_CFG_IRQ_POL_BIT]))
        else $error("level interrupt not asserted while pending");
    AST_IRQ_MASKED: assert property (
        $past(ce_i) && !$past(cfg[`MHP_CFG_IRQ_PULSE_BIT]) && !$past(|cur)
        |-> irq_out_pin_o == !$past(cfg[`MHP_CFG_IRQ_POL_BIT]))
        else $error("interrupt asserted with nothing pending");
    AST_W1C: assert property (
        ce_i && wr_stb && !ireset && !sreset && q.waddr == `MHP_REG_STATUS
        |=> (stat & $past(wval) & ~$past(event_i)) == 24'h000000
            && ((stat ^ $past(stat)) & ~$past(wval) & ~$past(event_i)) == 24'h000000)
        else $error("status clear wrong");
    AST_SET_WINS: assert property (
        ce_i && !ireset && !sreset |=> (stat & $past(event_i)) == $past(event_i))
        else $error("status event lost");
    AST_PULSE_LEN: assert property (
        $past(ce_i) && $past(q.pcnt) != 2'h0 && q.pcnt == 2'h0 && !$past(ireset) && !$past(sreset)
        |-> $past(tick) && $past(q.pcnt) == 2'h1)
        else $error("interrupt pulse ended early");
    AST_SOFT_RESET: assert property (
        ce_i && sreset && !ireset |=> q.pst == PS_RST_WAIT && cfg == `MHP_CFG_RST && stat == $past(event_i))
        else $error("soft reset did not restore defaults");
    AST_INIT_WAIT: assert property (
        q.pst == PS_RST_WAIT ##1 q.pst == PS_ACTIVE
        |-> $past(q.xcnt) == `MHP_INIT_LAST && $past(xrise) && stat[`MHP_READY_BIT])
        else $error("left reset wait early or without ready flag");
    AST_CS_IDLE: assert property (
        ce_i && !cs_act && !ireset |=> q.bitc == 3'h0 && q.tx == 32'h00000000 [*2])
        else $error("serial state moved with chip select high");
    AST_WRITE_24: assert property (
        wr_stb |-> srise && q.bitc == 3'h7 && q.wleft == 2'h1)
        else $error("write committed off the 24th clock");
    AST_READ_MSB: assert property (
        ce_i && rd_load && !ireset |=> sdo_o == q.regs[$past(byte_v[5:1])][23] && q.fresh)
        else $error("read data not MSB first");

    COV_READ: cover property (ce_i && rd_load ##[1:40] sfall);
    COV_WRITE: cover property (ce_i && wr_stb && q.waddr == `MHP_REG_STATUS);
    COV_RESYNC: cover property (ce_i && resync);
    COV_PULSE: cover property (q.pcnt == 2'h2 ##[1:200] q.pcnt == 2'h0);
    COV_SLEEP_WAKE: cover property (ce_i && sreset && q.pst == PS_SLEEP);

    // Power-state, command decoding and interrupt pulse format checks
    AST_PD_STANDBY: assert property (
        ce_i && byte_done && q.wleft == 2'h0 && !ireset && byte_v == (`MHP_CMD_PD_BASE | 8'h08)
        |=> q.pst == PS_STANDBY && q.halt)
        else $error("power-down to stand-by not taken");
    AST_PD_SLEEP: assert property (
        ce_i && byte_done && q.wleft == 2'h0 && !ireset && byte_v == (`MHP_CMD_PD_BASE | 8'h10)
        |=> q.pst == PS_SLEEP && q.halt)
        else $error("power-down to sleep not taken");
    AST_STANDBY_REF: assert property (
        q.pst == PS_STANDBY |-> ctl_o.ref_osc_on && !ctl_o.core_on)
        else $error("stand-by outputs wrong");
    AST_SLEEP_OFF: assert property (
        q.pst == PS_SLEEP |-> !ctl_o.ref_osc_on && !ctl_o.core_on)
        else $error("sleep outputs wrong");
    AST_PWRUP_SLEEP: assert property (
        ce_i && byte_done && q.wleft == 2'h0 && !ireset && byte_v == `MHP_CMD_PWRUP && q.pst == PS_SLEEP
        |=> q.pst == PS_RST_WAIT && cfg == `MHP_CFG_RST)
        else $error("power-up in sleep did not reinitialize");
    AST_SYNC_QUIET: assert property (
        ce_i && byte_done && q.wleft == 2'h0 && !ireset && byte_v[7:1] == 7'h7f
        |=> !q.halt && !q.start && q.pst == $past(q.pst))
        else $error("sync byte disturbed an operation");
    AST_IRQ_PULSE: assert property (
        $past(ce_i) && $past(cfg[`MHP_CFG_IRQ_PULSE_BIT])
        |-> irq_out_pin_o == (($past(q.pcnt) != 2'h0) ~^ $past(cfg[`MHP_CFG_IRQ_POL_BIT])))
        else $error("pulse interrupt format wrong");
    AST_START_CMD: assert property (
        ce_i && byte_done && q.wleft == 2'h0 && !ireset && active_v && byte_v == (`MHP_CMD_START_BASE | 8'h08)
        |=> q.start && q.continuous && q.halt)
        else $error("start command not decoded");
    AST_WRITE_LANDS: assert property (
        ce_i && wr_stb && !ireset && !sreset && q.waddr != `MHP_REG_STATUS
        |=> q.regs[$past(q.waddr)] == $past(wval))
        else $error("write data did not land");
endmodule // mhp_port_ctrl

// >>> bench/mhp_host.sv
`timescale 1ns/100ps
module mhp_host (
    // Clock
    input wire logic sys_clk_i,
    // Serial port
    output mhp_pkg::mhp_spi_t spi_o,
    input wire logic sdo_i
);
    import mhp_pkg::*;
    initial spi_o = 3'b100;
    // One byte out and in; the serial clock stands low between bits
    task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            spi_o.sdi = b[i];
            repeat (8) @(posedge sys_clk_i);
            #1 spi_o.sclk = 1'b1;
            r[i] = sdo_i;
            repeat (8) @(posedge sys_clk_i);
            #1 spi_o.sclk = 1'b0;
        end
    endtask
    // Command byte then nb data bytes; reads pad with filler bytes
    task automatic frame(input logic [7:0] c, input logic [23:0] wd, input int nb, output logic [23:0] rd);
        logic [7:0] r;
        rd = 24'h000000;
        @(posedge sys_clk_i);
        #1 spi_o.cs_n = 1'b0;
        repeat (8) @(posedge sys_clk_i);
        xbyte(c, r);
        for (int k = 0; k < nb; k++) begin
            xbyte(wd[23-8*k -: 8], r);
            rd = {rd[15:0], r};
        end
        repeat (8) @(posedge sys_clk_i);
        #1 spi_o.cs_n = 1'b1;
        spi_o.sdi = ~spi_o.sdi;
        repeat (8) @(posedge sys_clk_i);
        #1;
    endtask
endmodule // mhp_host

// >>> bench/meter_host_port_control_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module meter_host_port_control_bench;
    import mhp_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hw_n = 1'b1;
    logic agood = 1'b1;
    logic xtal = 1'b0;
    logic [23:0] ev = 24'h000000;
    logic sdo;
    logic irq;
    logic ce = 1'b1;
    int n_halt = 0;
    logic saw_start = 1'b0;
    logic [23:0] rd;
    int num_errors = 0;
    int n_tests = 0;
    int n;
    mhp_spi_t spi;
    mhp_ctl_t ctl;
    always #2.5 sys_clk_i = ~sys_clk_i;
    always #40 xtal = ~xtal;
    mhp_host i_mhp_host (.sys_clk_i(sys_clk_i), .spi_o(spi), .sdo_i(sdo));
    mhp_port_ctrl i_mhp_port_ctrl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .spi_i(spi),
        .sdo_o(sdo), .hw_reset_n_i(hw_n), .analog_good_i(agood), .crystal_input_i(xtal), .event_i(ev),
        .ctl_o(ctl), .irq_out_pin_o(irq));
    // One-cycle control pulses are latched so a test can look later
    always @(posedge sys_clk_i) begin
        if (ctl.halt === 1'b1) n_halt++;
        if (ctl.start === 1'b1 && ctl.continuous === 1'b1) saw_start <= 1'b1;
    end
    task automatic tally_and_finish;
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_ready;
        int i;
        for (i = 0; i < 2000 && ctl.device_ready !== 1'b1; i++) @(posedge sys_clk_i);
        if (i == 2000) begin
            num_errors++;
            tally_and_finish;
        end
        #1;
    endtask
    task automatic rd_reg(input logic [4:0] a);
        i_mhp_host.frame({2'b00, a, 1'b0}, 24'hffffff, 3, rd);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [23:0] d);
        i_mhp_host.frame({2'b01, a, 1'b0}, d, 3, rd);
    endtask
    task automatic ins(input logic [7:0] c);
        i_mhp_host.frame(c, 24'h000000, 0, rd);
    endtask
    initial begin
        tick(12);
        rst_n_i = 1'b1;
        wait_ready;
        `CHK(irq, 1'b1)
        rd_reg(5'h00);
        `CHK(rd, 24'h000001)
        rd_reg(5'h0f);
        `CHK(rd, 24'h800000)
        wr_reg(5'h1a, 24'h000001);
        wr_reg(5'h0f, 24'hffffff);
        ev = 24'h000003;
        tick(1);
        ev = 24'h000000;
        tick(3);
        `CHK(irq, 1'b0)
        wr_reg(5'h0f, 24'h000000);
        `CHK(irq, 1'b0)
        wr_reg(5'h0f, 24'h000001);
        `CHK(irq, 1'b1)
        rd_reg(5'h0f);
        `CHK(rd, 24'h000002)
        wr_reg(5'h01, 24'habcdef);
        i_mhp_host.frame(8'h1e, 24'h02ffff, 3, rd);
        `CHK(rd, 24'h00abcd)
        wr_reg(5'h00, 24'h000022);
        `CHK(irq, 1'b1)
        ev = 24'h000001;
        n = 0;
        for (int i = 0; i < 1000; i++) begin
            @(posedge sys_clk_i);
            #1;
            ev = 24'h000000;
            if (irq === 1'b0) n++;
        end
        `CHK(n >= 32 && n < 200, 1'b1)
        wr_reg(5'h00, 24'h000011);
        `CHK(irq, 1'b1)
        wr_reg(5'h0f, 24'hffffff);
        `CHK(irq, 1'b0)
        ins(8'he8);
        `CHK(saw_start, 1'b1)
        n = n_halt;
        ins(8'ha0);
        `CHK(n_halt - n, 1)
        i_mhp_host.frame(8'hff, 24'hfffffe, 3, rd);
        rd_reg(5'h01);
        `CHK(rd, 24'habcdef)
        ins(8'h88);
        `CHK({ctl.core_on, ctl.ref_osc_on}, 2'b01)
        rd_reg(5'h01);
        `CHK(rd, 24'h000000)
        ins(8'ha0);
        `CHK(ctl.core_on, 1'b1)
        ins(8'h90);
        `CHK({ctl.core_on, ctl.ref_osc_on}, 2'b00)
        ins(8'ha0);
        wait_ready;
        rd_reg(5'h01);
        `CHK(rd, 24'h000000)
        wr_reg(5'h00, 24'h000011);
        ins(8'h80);
        wait_ready;
        rd_reg(5'h00);
        `CHK(rd, 24'h000001)
        `CHK(irq, 1'b1)
        for (int p = 0; p < 2; p++) begin
            wr_reg(5'h01, 24'h123456);
            if (p == 0) hw_n = 1'b0;
            else agood = 1'b0;
            tick(10);
            `CHK(ctl.device_ready, 1'b0)
            hw_n = 1'b1;
            agood = 1'b1;
            wait_ready;
            rd_reg(5'h01);
            `CHK(rd, 24'h000000)
        end
        // Clock enable low freezes everything, pin filters included
        ce = 1'b0;
        hw_n = 1'b0;
        tick(10);
        `CHK(ctl.device_ready, 1'b1)
        hw_n = 1'b1;
        tick(4);
        ce = 1'b1;
        tick(10);
        `CHK(ctl.device_ready, 1'b1)
        tally_and_finish;
    end
endmodule // meter_host_port_control_bench
